// ===== rtl/dsadc_pkg.sv
// Package for the dual-slope converter control block: offsets, resets, timing.
// Assumes a 10 MHz system clock and 4-bit registers on an 8-bit address port.
package dsadc_pkg;
	localparam logic [7:0] ADDR_DONE_FLAG  = 8'hc4;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'hc8;
	localparam logic [7:0] ADDR_POWER_CTRL = 8'hf0;
	localparam logic [7:0] ADDR_RESOLUTION = 8'hf3;
	localparam logic [7:0] ADDR_PAIR_MODE  = 8'hf4;
	localparam logic [7:0] ADDR_INPUT_LOW  = 8'hf5;
	localparam logic [7:0] ADDR_CLEAR_RUN  = 8'hf6;
	localparam logic [7:0] ADDR_COUNT_0    = 8'hf7;
	localparam logic [7:0] ADDR_COUNT_1    = 8'hf8;
	localparam logic [7:0] ADDR_COUNT_2    = 8'hf9;
	localparam logic [7:0] ADDR_COUNT_TOP  = 8'hfa;
	localparam logic [7:0] ADDR_VALIDITY   = 8'hfb;

	localparam int unsigned BIT_CONV_MASK    = 2;
	localparam int unsigned BIT_RUN          = 3;
	localparam int unsigned BIT_POLARITY     = 1;
	localparam logic [3:0]  RESET_NIBBLE     = 4'h0;

	localparam int unsigned CLK_HZ           = 10_000_000;
	// Full-resolution (slowest setting) conversion time in microseconds; others halve it per step
	localparam int unsigned CONV_TIME_US     = 500_000;
	localparam int unsigned CONV_CYCLES      = CONV_TIME_US / 1_000_000 * CLK_HZ
		+ (CONV_TIME_US % 1_000_000) * (CLK_HZ / 1_000_000);
	localparam logic [12:0] FULL_COUNTS      = 13'h1998;
	// Fastest setting does not follow the halving pattern
	localparam logic [12:0] FAST_COUNTS      = 13'h0334;

	typedef enum logic [1:0] {ST_IDLE, ST_INTEGRATE, ST_DEINTEGRATE} conv_state_t;

	typedef struct packed {
		logic       ground_drive_sel_hi;
		logic       ground_drive_sel_lo;
		logic       vref_adjust_on;
		logic       vref_internal_on;
	} power_ctrl_t;

	typedef struct packed {
		logic [12:0] count_value;
		logic        polarity_bit;
	} result_t;
endpackage : dsadc_pkg

// ===== rtl/dual_slope_adc_control.sv
// Dual-slope converter control: register file, conversion sequencer, readout.
// Assumes a comparator input from the analogue integrator and one-cycle strobes.
// Behaviour
// - Done flag bit 0 reads 1 when set, clears on read, resets 0.
// - Mask bits: converter 2, serial 1, timer 0; 1 enables; bit 3 zero.
// - Unused bits read 0 and ignore writes.
// - Ground drive field bits 3:2: off, x1, x2, x4; resets 00.
// - Power bit 0 selects internal reference when 1; resets 0.
// - Power bit 1 turns reference adjustment on; resets 0.
// - Resolution field picks counts and time, halving per step except fastest counts; resets 00.
// - Pair-mode register bits select differential/resistance per input pair.
// - Inputs 0-3 enables in one register, input 4 in clear/run bit 0.
// - Clear/run bit 3 read/write, resets 0, runs converter when 1.
// - Thirteen-bit count over four read-only nibbles, bit 12 in top bit 0.
// - Polarity detected automatically, top register bit 1, 1 positive.
// - Dual-slope conversion with software-selectable time and resolution.
// - Writing 1 to clear/run resets counter and state, starts conversion.
// - End of reverse integration sets flag; irq only when mask set.
// - Reads lowest to highest, validity reads 1 when data invalid.
`timescale 1ns/1ns
`default_nettype none
module dual_slope_adc_control
	import dsadc_pkg::*;
#(
	parameter int unsigned CONV_CYCLES_P = CONV_CYCLES
)(
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       clk_en,
	input  wire logic [7:0] addr,
	input  wire logic [3:0] wdata,
	input  wire logic       wr_strobe,
	input  wire logic       rd_strobe,
	output logic      [3:0] rdata,
	input  wire logic       comparator_pos,
	input  wire logic       integrator_zero,
	output logic            conv_irq,
	output logic            serial_irq_mask,
	output logic            prog_timer_irq_mask,
	output logic      [1:0] ground_sel,
	output logic            vref_internal_on,
	output logic            vref_adjust_on,
	output logic      [3:0] pair_mode,
	output logic      [4:0] input_enable,
	output logic            integrate_input,
	output logic            integrate_reference,
	output logic            reference_sign
);

////////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic        conv_done_flag;
		logic [2:0]  irq_mask;
		power_ctrl_t power;
		logic [1:0]  resolution;
		logic [3:0]  pair_mode;
		logic [4:0]  input_enable;
		logic        conv_clear_run;
		conv_state_t state;
		logic [22:0] timer;
		logic [12:0] counter;
		logic        sign;
		result_t     result;
		logic        readout_invalid;
		logic        read_seq_ok;
		logic        changed_during_read;
		logic [3:0]  rdata;
	} state_t;

	state_t cur;
	state_t nxt;

	logic [22:0] int_cycles;
	logic [12:0] max_counts;
	logic [3:0]  read_mux;
	logic        conv_complete;

	// Integration period and count ceiling scale by the resolution field
	always_comb
	begin
		// Shift amount widened so the fastest setting does not wrap to zero
		int_cycles = 23'(CONV_CYCLES_P >> ({1'b0, cur.resolution} + 3'd1));
		if (cur.resolution == 2'd3)
			max_counts = FAST_COUNTS;
		else
			max_counts = 13'(FULL_COUNTS >> cur.resolution);
	end

	always_comb
	begin
		read_mux = 4'h0;
		unique case (addr)
			ADDR_DONE_FLAG:  read_mux = {3'h0, cur.conv_done_flag};
			ADDR_IRQ_MASK:   read_mux = {1'b0, cur.irq_mask};
			ADDR_POWER_CTRL: read_mux = cur.power;
			ADDR_RESOLUTION: read_mux = {2'h0, cur.resolution};
			ADDR_PAIR_MODE:  read_mux = cur.pair_mode;
			ADDR_INPUT_LOW:  read_mux = cur.input_enable[3:0];
			ADDR_CLEAR_RUN:  read_mux = {cur.conv_clear_run, 2'h0, cur.input_enable[4]};
			ADDR_COUNT_0:    read_mux = cur.result.count_value[3:0];
			ADDR_COUNT_1:    read_mux = cur.result.count_value[7:4];
			ADDR_COUNT_2:    read_mux = cur.result.count_value[11:8];
			ADDR_COUNT_TOP:  read_mux = {2'h0, cur.result.polarity_bit, cur.result.count_value[12]};
			ADDR_VALIDITY:   read_mux = {3'h0, cur.readout_invalid};
			default:         read_mux = 4'h0;
		endcase
	end

////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		nxt = cur;
		conv_complete = 1'b0;
		nxt.rdata = rd_strobe ? read_mux : 4'h0;

		// Sequencer: run-up for a fixed time, then run-down until zero crossing or the count ceiling
		unique case (cur.state)
			ST_IDLE:
			begin
				nxt.timer = 23'h0;
			end
			ST_INTEGRATE:
			begin
				nxt.timer = cur.timer + 23'h1;
				if (cur.timer + 23'h1 >= int_cycles)
				begin
					nxt.state   = ST_DEINTEGRATE;
					nxt.sign    = comparator_pos;
					nxt.counter = 13'h0;
				end
			end
			ST_DEINTEGRATE:
			begin
				nxt.counter = cur.counter + 13'h1;
				if (integrator_zero || cur.counter + 13'h1 >= max_counts)
				begin
					nxt.state                = ST_INTEGRATE;
					nxt.timer                = 23'h0;
					nxt.result.count_value   = integrator_zero ? cur.counter : max_counts;
					nxt.result.polarity_bit  = cur.sign;
					nxt.conv_done_flag       = 1'b1;
					conv_complete            = 1'b1;
					nxt.changed_during_read  = 1'b1;
				end
			end
			default:
				nxt.state = ST_IDLE;
		endcase

		// Readout sequence tracking: a new result mid-sequence marks it invalid
		if (rd_strobe)
		begin
			if (addr == ADDR_COUNT_0)
			begin
				nxt.read_seq_ok         = 1'b1;
				nxt.changed_during_read = 1'b0;
			end
			else if (addr == ADDR_VALIDITY)
				nxt.read_seq_ok = 1'b0;
			if (addr == ADDR_COUNT_TOP)
				nxt.readout_invalid = !cur.read_seq_ok || cur.changed_during_read;
		end

		// Read clears the flag, but a completion in the same cycle wins
		if (rd_strobe && addr == ADDR_DONE_FLAG && !conv_complete)
			nxt.conv_done_flag = 1'b0;

		if (wr_strobe)
		begin
			unique case (addr)
				ADDR_IRQ_MASK:   nxt.irq_mask = wdata[2:0];
				ADDR_POWER_CTRL: nxt.power = wdata;
				ADDR_RESOLUTION: nxt.resolution = wdata[1:0];
				ADDR_PAIR_MODE:  nxt.pair_mode = wdata;
				ADDR_INPUT_LOW:  nxt.input_enable[3:0] = wdata[3:0];
				ADDR_CLEAR_RUN:
				begin
					nxt.input_enable[4] = wdata[0];
					nxt.conv_clear_run  = wdata[BIT_RUN];
					if (wdata[BIT_RUN])
					begin
						nxt.state   = ST_INTEGRATE;
						nxt.timer   = 23'h0;
						nxt.counter = 13'h0;
					end
					else
						nxt.state = ST_IDLE;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			cur <= '0;
		else if (clk_en)
			cur <= nxt;
	end

////////////////////////////////////////////////////////////////////////////////

	assign rdata               = cur.rdata;
	assign conv_irq            = cur.conv_done_flag & cur.irq_mask[BIT_CONV_MASK];
	assign serial_irq_mask     = cur.irq_mask[1];
	assign prog_timer_irq_mask = cur.irq_mask[0];
	assign ground_sel          = {cur.power.ground_drive_sel_hi, cur.power.ground_drive_sel_lo};
	assign vref_internal_on    = cur.power.vref_internal_on;
	assign vref_adjust_on      = cur.power.vref_adjust_on;
	assign pair_mode           = cur.pair_mode;
	assign input_enable        = cur.input_enable;
	assign integrate_input     = cur.state == ST_INTEGRATE;
	assign integrate_reference = cur.state == ST_DEINTEGRATE;
	assign reference_sign      = cur.sign;

////////////////////////////////////////////////////////////////////////////////

	chk_flag_read_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_DONE_FLAG && cur.state != ST_DEINTEGRATE
		|=> !cur.conv_done_flag)
		else $error("done flag not cleared by read");

	chk_read_data_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_DONE_FLAG |=> rdata == {3'h0, $past(cur.conv_done_flag)})
		else $error("done flag read wrong");

	chk_mask_top_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_IRQ_MASK |=> rdata[3] == 1'b0)
		else $error("mask bit 3 not zero");

	chk_unused_bits_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_CLEAR_RUN |=> rdata[2:1] == 2'h0)
		else $error("unused bits not zero");

	chk_ground_drive_out: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && wr_strobe && addr == ADDR_POWER_CTRL |=> ground_sel == $past(wdata[3:2]))
		else $error("ground drive not updated");

	chk_vref_bits_out: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && wr_strobe && addr == ADDR_POWER_CTRL
		|=> vref_internal_on == $past(wdata[0]) && vref_adjust_on == $past(wdata[1]))
		else $error("reference bits not updated");

	chk_run_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && wr_strobe && addr == ADDR_CLEAR_RUN && wdata[3]
		|=> integrate_input && cur.timer == 23'h0)
		else $error("clear/run did not restart");

	chk_run_stop: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && wr_strobe && addr == ADDR_CLEAR_RUN && !wdata[3] |=> cur.state == ST_IDLE)
		else $error("converter not stopped");

	chk_irq_masked: assert property (@(posedge clk_sys) disable iff (!resetn)
		!cur.irq_mask[BIT_CONV_MASK] |-> !conv_irq)
		else $error("interrupt raised while masked");

	chk_done_sets_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && cur.state == ST_DEINTEGRATE && integrator_zero && !wr_strobe
		|=> cur.conv_done_flag && cur.result.count_value == $past(cur.counter))
		else $error("completion not latched");

	chk_ro_write_ignored: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && wr_strobe && addr == ADDR_COUNT_0 && cur.state == ST_IDLE
		|=> $stable(cur.result))
		else $error("read-only write changed result");

////////////////////////////////////////////////////////////////////////////////
// Read path, write path and sequencer checks

	chk_rdata_idle_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && !rd_strobe |=> rdata == 4'h0)
		else $error("read data not zero without read");

	chk_read_power_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_POWER_CTRL
		|=> rdata == $past({ground_sel, vref_adjust_on, vref_internal_on}))
		else $error("power register read wrong");

	chk_read_res_unused: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_RESOLUTION |=> rdata[3:2] == 2'h0)
		else $error("resolution unused bits not zero");

	chk_read_pair_mode: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_PAIR_MODE |=> rdata == $past(pair_mode))
		else $error("pair mode read wrong");

	chk_read_inputs_low: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_INPUT_LOW |=> rdata == $past(input_enable[3:0]))
		else $error("input enables read wrong");

	chk_read_input_four: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_CLEAR_RUN |=> rdata[0] == $past(input_enable[4]))
		else $error("input four read wrong");

	chk_read_run_bit: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_CLEAR_RUN
		|=> rdata[3] == $past(integrate_input || integrate_reference))
		else $error("run bit read wrong");

	chk_read_valid_unused: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_VALIDITY |=> rdata[3:1] == 3'h0)
		else $error("validity unused bits not zero");

	chk_read_top_unused: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_COUNT_TOP |=> rdata[3:2] == 2'h0)
		else $error("count top unused bits not zero");

	chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr < ADDR_DONE_FLAG |=> rdata == 4'h0)
		else $error("unmapped read not zero");

	chk_mask_write_out: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && wr_strobe && addr == ADDR_IRQ_MASK
		|=> {serial_irq_mask, prog_timer_irq_mask} == $past(wdata[1:0]))
		else $error("mask outputs not updated");

	chk_res_write_taken: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && wr_strobe && addr == ADDR_RESOLUTION |=> cur.resolution == $past(wdata[1:0]))
		else $error("resolution not updated");

	chk_pair_write_out: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && wr_strobe && addr == ADDR_PAIR_MODE |=> pair_mode == $past(wdata))
		else $error("pair mode not updated");

	chk_inputs_write_out: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && wr_strobe && addr == ADDR_INPUT_LOW |=> input_enable[3:0] == $past(wdata))
		else $error("input enables not updated");

	chk_input4_write_out: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && wr_strobe && addr == ADDR_CLEAR_RUN |=> input_enable[4] == $past(wdata[0]))
		else $error("input four not updated");

	chk_rundown_after_runup: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(integrate_reference) |-> $past(integrate_input))
		else $error("run-down without run-up");

	chk_zero_ends_rundown: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && integrate_reference && integrator_zero && !wr_strobe |=> integrate_input)
		else $error("zero crossing did not end run-down");

	chk_sign_latched: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(integrate_reference) |-> reference_sign == $past(comparator_pos))
		else $error("polarity not latched at run-up end");

	chk_frozen_state: assert property (@(posedge clk_sys) disable iff (!resetn)
		!clk_en |=> $stable(cur))
		else $error("state changed while clock enable low");

	chk_flag_set_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_DONE_FLAG && integrate_reference && integrator_zero
		|=> cur.conv_done_flag)
		else $error("read clear beat completion");

	chk_stopped_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
		!cur.conv_clear_run |-> !integrate_input && !integrate_reference)
		else $error("converter active while off");

	chk_invalid_marked: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && rd_strobe && addr == ADDR_COUNT_TOP && !cur.read_seq_ok |=> cur.readout_invalid)
		else $error("out of order read not marked invalid");

	chk_top_write_ignored: assert property (@(posedge clk_sys) disable iff (!resetn)
		clk_en && wr_strobe && addr == ADDR_COUNT_TOP && !integrate_reference
		|=> $stable(cur.result))
		else $error("write to count top changed result");

endmodule : dual_slope_adc_control
`default_nettype wire

// ===== dv/dual_slope_adc_control_tb.sv
// Self-checking bench for the dual-slope converter control block.
// Assumes the design package and a short run-up parameter for simulation speed.
`timescale 1ns/1ns
`default_nettype none
module dual_slope_adc_control_tb;
	import dsadc_pkg::*;
	logic       clk_sys;
	logic       resetn;
	logic       clk_en;
	logic [7:0] addr;
	logic [3:0] wdata;
	logic       wr_strobe;
	logic       rd_strobe;
	logic [3:0] rdata;
	logic       comparator_pos;
	logic       integrator_zero;
	logic       conv_irq;
	logic       serial_irq_mask;
	logic       prog_timer_irq_mask;
	logic [1:0] ground_sel;
	logic       vref_internal_on;
	logic       vref_adjust_on;
	logic [3:0] pair_mode;
	logic [4:0] input_enable;
	logic       integrate_input;
	logic       integrate_reference;
	logic       reference_sign;
	int         n_fail;
	int         comparisons;
	dual_slope_adc_control #(.CONV_CYCLES_P(64)) uut (
		.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .addr(addr), .wdata(wdata),
		.wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
		.comparator_pos(comparator_pos), .integrator_zero(integrator_zero), .conv_irq(conv_irq),
		.serial_irq_mask(serial_irq_mask), .prog_timer_irq_mask(prog_timer_irq_mask),
		.ground_sel(ground_sel), .vref_internal_on(vref_internal_on), .vref_adjust_on(vref_adjust_on),
		.pair_mode(pair_mode), .input_enable(input_enable), .integrate_input(integrate_input),
		.integrate_reference(integrate_reference), .reference_sign(reference_sign));
	always #50 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [3:0] d);
		@(posedge clk_sys);
		addr      <= a;
		wdata     <= d;
		wr_strobe <= 1'b1;
		@(posedge clk_sys);
		wr_strobe <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [3:0] exp);
		@(posedge clk_sys);
		addr      <= a;
		rd_strobe <= 1'b1;
		@(posedge clk_sys);
		rd_strobe <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), {1'b0, exp}, {1'b0, rdata});
	endtask : rd
	// Bounded wait for the run-down output to reach a level
	task automatic wait_ref(input logic lvl);
		int i;
		for (i = 0; i < 2000 && integrate_reference !== lvl; i++)
			@(posedge clk_sys);
		chk("run-down wait", {4'h0, lvl}, {4'h0, integrate_reference});
	endtask : wait_ref
	task automatic finish_test;
		$display("checks %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////////////
	logic [7:0] all_regs [12] = '{8'hc4, 8'hc8, 8'hf0, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hfb};
	initial
	begin
		clk_sys = 1'b0; resetn = 1'b0; clk_en = 1'b1; addr = 8'h00; wdata = 4'h0;
		wr_strobe = 1'b0; rd_strobe = 1'b0; comparator_pos = 1'b1; integrator_zero = 1'b0;
		n_fail = 0; comparisons = 0;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		foreach (all_regs[i]) rd(all_regs[i], 4'h0);
		wr(8'hf0, 4'hf);
		rd(8'hf0, 4'hf);
		chk("ground", 5'h03, {3'h0, ground_sel});
		chk("vref", 5'h03, {3'h0, vref_internal_on, vref_adjust_on});
		wr(8'hf0, 4'h4);
		chk("ground x1", 5'h01, {3'h0, ground_sel});
		chk("vref off", 5'h00, {3'h0, vref_internal_on, vref_adjust_on});
		wr(8'hf3, 4'hf);
		rd(8'hf3, 4'h3);
		// Writes while the clock enable is low must leave the registers alone
		@(posedge clk_sys);
		clk_en <= 1'b0;
		wr(8'hf3, 4'h0);
		@(posedge clk_sys);
		clk_en <= 1'b1;
		rd(8'hf3, 4'h3);
		wr(8'hf4, 4'ha);
		rd(8'hf4, 4'ha);
		chk("pair", 5'h0a, {1'b0, pair_mode});
		wr(8'hf5, 4'hf);
		wr(8'hf6, 4'h7);
		rd(8'hf6, 4'h1);
		chk("inputs", 5'h1f, input_enable);
		wr(8'hc8, 4'hf);
		rd(8'hc8, 4'h7);
		chk("masks", 5'h03, {3'h0, serial_irq_mask, prog_timer_irq_mask});
		wr(8'he0, 4'hf);
		rd(8'he0, 4'h0);
		wr(8'hc4, 4'hf);
		rd(8'hc4, 4'h0);
		// Ground-referenced measurement of input 0, fastest resolution
		wr(8'hf4, 4'h0);
		wr(8'hf5, 4'h1);
		wr(8'hf3, 4'h3);
		wr(8'hc8, 4'h4);
		wr(8'hf6, 4'h8);
		repeat (2) @(posedge clk_sys);
		chk("run-up", 5'h01, {4'h0, integrate_input});
		wait_ref(1'b1);
		wr(8'hf7, 4'hf);
		wait_ref(1'b0);
		repeat (2) @(posedge clk_sys);
		chk("irq on", 5'h01, {4'h0, conv_irq});
		rd(8'hc4, 4'h1);
		rd(8'hc4, 4'h0);
		rd(8'hf7, FAST_COUNTS[3:0]);
		rd(8'hf8, FAST_COUNTS[7:4]);
		rd(8'hf9, FAST_COUNTS[11:8]);
		rd(8'hfa, {2'h0, 1'b1, FAST_COUNTS[12]});
		rd(8'hfb, 4'h0);
		rd(8'hfa, {2'h0, 1'b1, FAST_COUNTS[12]});
		rd(8'hfb, 4'h1);
		// Masked completion, negative input, early zero crossing
		wr(8'hc8, 4'h0);
		comparator_pos <= 1'b0;
		wr(8'hf6, 4'h8);
		wait_ref(1'b1);
		repeat (5) @(posedge clk_sys);
		integrator_zero <= 1'b1;
		wait_ref(1'b0);
		integrator_zero <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("irq masked", 5'h00, {4'h0, conv_irq});
		rd(8'hc4, 4'h1);
		rd(8'hfa, 4'h0);
		wr(8'hf6, 4'h0);
		repeat (3) @(posedge clk_sys);
		chk("stopped", 5'h00, {3'h0, integrate_input, integrate_reference});
		rd(8'hf6, 4'h0);
		// Differential and resistance set-ups
		wr(8'hf4, 4'h1);
		wr(8'hf5, 4'h3);
		chk("diff inputs", 5'h03, input_enable);
		wr(8'hf4, 4'h4);
		wr(8'hf5, 4'h4);
		wr(8'hf6, 4'h1);
		chk("res inputs", 5'h14, input_enable);
		chk("res pair", 5'h04, {1'b0, pair_mode});
		// Reset with the converter stopped returns pair mode, clear/run and resolution to zero
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(8'hf4, 4'h0);
		rd(8'hf6, 4'h0);
		rd(8'hf3, 4'h0);
		finish_test();
	end
	initial
	begin
		#(100 * 20000);
		n_fail++;
		finish_test();
	end
endmodule : dual_slope_adc_control_tb
`default_nettype wire
